// *** rtl/spid_pkg.sv ***
// Purpose: Shared constants and types for the scan port instruction and
//          identification logic.
// Assumes: Three-bit instruction register and a 109-cell boundary path.
// Notes:   Identification word is assembled here from the part options.
// Overview of operation
// - Code 000 puts the boundary scan register between data in and out.
// - Code 001 shifts the 32-bit identification word out.
// - Code 010 selects the boundary register and holds outputs high-Z.
// - Code 100 selects the boundary register for sample and preload.
// - Code 111 places the one-bit bypass register in the path.
// - Word: revision 31:29, part configuration 28:12, vendor code 11:1.
// - Bit 0 is a start bit fixed at one, shifted out first.
// - Plus-generation flag is 1 enhanced, 0 base generation.
// - Burst flag 1 for burst of four, 0 for burst of two.
// - I/O flag 1 for separate data in/out pins, 0 shared.
// - Termination flag 1 when on-die termination offered, else 0.
// - Instruction capture loads the two low bits with 01.
// - Reset and test-logic-reset load the identification instruction.

package spid_pkg;

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  localparam int IR_W = 3;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLEZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [2:0] IR_RESET = INS_IDCODE;
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;

  // ----------------------------------------------------------------
  // Data registers and identification layout
  // ----------------------------------------------------------------
  localparam int ID_W = 32;
  localparam int BSR_LEN = 109;
  localparam int BSR_OE_BIT = 108;
  localparam int REV_LSB = 29;
  localparam int CFG_LSB = 12;
  localparam int VEN_LSB = 1;
  localparam logic [1:0] CFG_FIXED_PAT = 2'h1;
  localparam logic [2:0] DENS_18MB = 3'h1;
  localparam logic [2:0] DENS_36MB = 3'h2;
  localparam logic [2:0] DENS_72MB = 3'h3;
  localparam logic [1:0] WIDTH_X36 = 2'h3;
  localparam logic [1:0] WIDTH_X18 = 2'h2;

  // Part options that shape the configuration field
  typedef struct packed {
    logic [2:0] density_code;
    logic [1:0] word_width_code;
    logic plus_gen;
    logic sep_ports;
    logic read_latency;
    logic burst4;
    logic sep_io;
    logic odt;
  } spid_part_t;

  // Serial inputs from the test controller
  typedef struct packed {
    logic tms;
    logic tdi;
  } spid_scan_in_t;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } spid_tap_t;

  // Builds the 32-bit identification word
  function automatic logic [31:0] spid_id_word(input logic [2:0] rev,
    input spid_part_t p, input logic [10:0] vendor);
    logic [16:0] cfg;
    cfg = {1'b0, p.odt,
      p.density_code, 1'b0,
      p.word_width_code, CFG_FIXED_PAT,
      p.plus_gen, p.sep_ports,
      p.read_latency, p.burst4,
      p.odt, p.sep_io, 1'b0};
    return {rev, cfg, vendor, 1'b1};
  endfunction

endpackage

// *** rtl/spid_tap.sv ***
// Purpose: Test access port with instruction decode and identification.
// Assumes: Controller drives tms/tdi on tck; tdo changes on falling tck.
// Notes:   Instruction status is carried to clk_i by a toggle crossing.
`timescale 1ns/1ns

module spid_tap
  import spid_pkg::*;
#(
  parameter logic [2:0] REVISION = 3'h0,
  parameter spid_part_t PART = '{DENS_18MB, WIDTH_X36, 1'b0, 1'b1, 1'b0,
    1'b0, 1'b1, 1'b0},
  parameter logic [10:0] VENDOR = 11'h155  // Arbitrary value
)
(
  // System clock domain
  input wire logic clk_i,
  input wire logic rst_i,
  output logic [2:0] instr_o,
  output logic instr_upd_o,
  // Scan link
  input wire logic tck_i,
  input wire spid_scan_in_t scan_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // Boundary ring
  input wire logic [BSR_LEN-1:0] bsr_pins_i,
  output logic [BSR_LEN-1:0] preload_o,
  output logic q_drive_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  spid_tap_t state_r;
  spid_tap_t state_nxt;
  logic rs1_r, rs2_r, rs3_r;
  logic tap_rst;
  logic tap_rst_r;
  logic [2:0] ir_r;
  logic [2:0] ir_sh_r;
  logic ir_tgl_r;
  logic [ID_W-1:0] id_sh_r;
  logic [BSR_LEN-1:0] bsr_sh_r;
  logic [BSR_LEN-1:0] preload_r;
  logic byp_r;
  logic tdo_r;
  logic tdo_oe_r;
  logic q_drive_r;
  logic t1_r, t2_r, t3_r, seen_r;
  logic [2:0] instr_r;
  logic upd_r;
  logic [ID_W-1:0] id_word;

  assign id_word = spid_id_word(REVISION, PART, VENDOR);

  // True for codes that route through the boundary register
  function automatic logic is_bsr(input logic [2:0] ins);
    return (ins == INS_EXTEST) || (ins == INS_SAMPLEZ) ||
      (ins == INS_SAMPLE);
  endfunction

  // Output bus enable for an instruction and the latched internal cell
  function automatic logic drive_of(input logic [2:0] ins, input logic oe);
    return (ins == INS_EXTEST) ? oe : (ins != INS_SAMPLEZ);
  endfunction

  // LSB of the data register selected by an instruction
  function automatic logic dr_lsb(input logic [2:0] ins,
    input logic [ID_W-1:0] id, input logic [BSR_LEN-1:0] bsr,
    input logic byp);
    if (is_bsr(ins))
    begin
      return bsr[0];
    end
    else if (ins == INS_IDCODE)
    begin
      return id[0];
    end
    else
    begin
      // Reserved codes fall back to bypass so the chain stays intact
      return byp;
    end
  endfunction

  // ----------------------------------------------------------------
  // Reset crossing into the scan domain
  // ----------------------------------------------------------------
  // Three stages; reset is seen once the last two agree
  always_ff @(posedge tck_i)
  begin
    rs1_r <= rst_i;
    rs2_r <= rs1_r;
    rs3_r <= rs2_r;
    if (rs2_r == rs3_r)
    begin
      tap_rst_r <= rs3_r;
    end
  end

  assign tap_rst = tap_rst_r;

  // ----------------------------------------------------------------
  // Controller state machine
  // ----------------------------------------------------------------
  // Next state from tms
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      TLR: state_nxt = scan_i.tms ? TLR : RTI;
      RTI: state_nxt = scan_i.tms ? SEL_DR : RTI;
      SEL_DR: state_nxt = scan_i.tms ? SEL_IR : CAP_DR;
      CAP_DR: state_nxt = scan_i.tms ? EX1_DR : SH_DR;
      SH_DR: state_nxt = scan_i.tms ? EX1_DR : SH_DR;
      EX1_DR: state_nxt = scan_i.tms ? UPD_DR : PA_DR;
      PA_DR: state_nxt = scan_i.tms ? EX2_DR : PA_DR;
      EX2_DR: state_nxt = scan_i.tms ? UPD_DR : SH_DR;
      UPD_DR: state_nxt = scan_i.tms ? SEL_DR : RTI;
      SEL_IR: state_nxt = scan_i.tms ? TLR : CAP_IR;
      CAP_IR: state_nxt = scan_i.tms ? EX1_IR : SH_IR;
      SH_IR: state_nxt = scan_i.tms ? EX1_IR : SH_IR;
      EX1_IR: state_nxt = scan_i.tms ? UPD_IR : PA_IR;
      PA_IR: state_nxt = scan_i.tms ? EX2_IR : PA_IR;
      EX2_IR: state_nxt = scan_i.tms ? UPD_IR : SH_IR;
      UPD_IR: state_nxt = scan_i.tms ? SEL_DR : RTI;
      default: state_nxt = TLR;
    endcase
  end

  // State register; five high tms edges always land in TLR
  always_ff @(posedge tck_i)
  begin
    if (tap_rst)
    begin
      state_r <= TLR;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Instruction path
  // ----------------------------------------------------------------
  // Shift stage: capture pattern, then shift toward tdo
  always_ff @(posedge tck_i)
  begin
    if (tap_rst)
    begin
      ir_sh_r <= IR_RESET;
    end
    else if (state_r == CAP_IR)
    begin
      ir_sh_r <= {1'b0, IR_CAPTURE_PAT};
    end
    else if (state_r == SH_IR)
    begin
      ir_sh_r <= {scan_i.tdi, ir_sh_r[2:1]};
    end
  end

  // Active instruction; the toggle flags each change for clk_i
  always_ff @(posedge tck_i)
  begin
    if (tap_rst)
    begin
      ir_r <= IR_RESET;
      ir_tgl_r <= 1'b0;
    end
    else if (state_r == TLR)
    begin
      ir_r <= IR_RESET;
      ir_tgl_r <= ir_tgl_r ^ (ir_r != IR_RESET);
    end
    else if (state_r == UPD_IR)
    begin
      ir_r <= ir_sh_r;
      ir_tgl_r <= ~ir_tgl_r;
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  // Identification word: loaded at capture, LSB first out
  always_ff @(posedge tck_i)
  begin
    if (tap_rst)
    begin
      id_sh_r <= '0;
    end
    else if (state_r == CAP_DR && ir_r == INS_IDCODE)
    begin
      id_sh_r <= id_word;
    end
    else if (state_r == SH_DR && ir_r == INS_IDCODE)
    begin
      id_sh_r <= {scan_i.tdi, id_sh_r[ID_W-1:1]};
    end
  end

  // Bypass cell: cleared at capture, one stage of delay
  always_ff @(posedge tck_i)
  begin
    if (tap_rst)
    begin
      byp_r <= 1'b0;
    end
    else if (state_r == CAP_DR)
    begin
      byp_r <= 1'b0;
    end
    else if (state_r == SH_DR)
    begin
      byp_r <= scan_i.tdi;
    end
  end

  // Boundary path; the internal cell captures its own preload value
  always_ff @(posedge tck_i)
  begin
    if (tap_rst)
    begin
      bsr_sh_r <= '0;
    end
    else if (state_r == CAP_DR && is_bsr(ir_r))
    begin
      bsr_sh_r <= {preload_r[BSR_OE_BIT], bsr_pins_i[BSR_OE_BIT-1:0]};
    end
    else if (state_r == SH_DR && is_bsr(ir_r))
    begin
      bsr_sh_r <= {scan_i.tdi, bsr_sh_r[BSR_LEN-1:1]};
    end
  end

  // Preload latch changes only under sample or external test
  always_ff @(posedge tck_i)
  begin
    if (tap_rst)
    begin
      preload_r <= '0;
    end
    else if (state_r == UPD_DR &&
      (ir_r == INS_SAMPLE || ir_r == INS_EXTEST))
    begin
      preload_r <= bsr_sh_r;
    end
  end

  // Output bus drive follows the incoming instruction and cell value, so
  // the bus changes at the same tck edge even if tck then stops
  always_ff @(posedge tck_i)
  begin
    if (tap_rst || state_r == TLR)
    begin
      q_drive_r <= 1'b1;  // Identification instruction leaves bus driven
    end
    else if (state_r == UPD_IR)
    begin
      q_drive_r <= drive_of(ir_sh_r, preload_r[BSR_OE_BIT]);
    end
    else if (state_r == UPD_DR && ir_r == INS_EXTEST)
    begin
      q_drive_r <= bsr_sh_r[BSR_OE_BIT];
    end
    else
    begin
      q_drive_r <= drive_of(ir_r, preload_r[BSR_OE_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // Serial output on the falling edge
  // ----------------------------------------------------------------
  // Falling edge gives the controller a full half period of hold
  always_ff @(negedge tck_i)
  begin
    if (tap_rst)
    begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end
    else
    begin
      tdo_oe_r <= (state_r == SH_DR) || (state_r == SH_IR);
      if (state_r == SH_IR)
      begin
        tdo_r <= ir_sh_r[0];
      end
      else
      begin
        tdo_r <= dr_lsb(ir_r, id_sh_r, bsr_sh_r, byp_r);
      end
    end
  end

  // ----------------------------------------------------------------
  // Instruction status crossing into clk_i
  // ----------------------------------------------------------------
  // Word is stable for many tck periods after each toggle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      t1_r <= 1'b0;
      t2_r <= 1'b0;
      t3_r <= 1'b0;
      seen_r <= 1'b0;
      instr_r <= IR_RESET;
      upd_r <= 1'b0;
    end
    else
    begin
      t1_r <= ir_tgl_r;
      t2_r <= t1_r;
      t3_r <= t2_r;
      upd_r <= 1'b0;
      if (t2_r == t3_r && t3_r != seen_r)
      begin
        seen_r <= t3_r;
        instr_r <= ir_r;
        upd_r <= 1'b1;
      end
    end
  end

  assign instr_o = instr_r;
  assign instr_upd_o = upd_r;
  assign tdo_o = tdo_r;
  assign tdo_oe_o = tdo_oe_r;
  assign preload_o = preload_r;
  assign q_drive_o = q_drive_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ir_capture;
    @(posedge tck_i) disable iff (tap_rst)
    state_r == CAP_IR |=> ir_sh_r[1:0] == 2'h1;
  endproperty
  a_ir_capture: assert property (p_ir_capture)
    else $error("capture pattern not loaded");

  property p_ir_reset;
    @(posedge tck_i) disable iff (tap_rst)
    scan_i.tms [*5] |=> state_r == TLR ##1 ir_r == 3'h1;
  endproperty
  a_ir_reset: assert property (p_ir_reset)
    else $error("reset did not restore id instruction");

  property p_id_capture;
    @(posedge tck_i) disable iff (tap_rst)
    (state_r == CAP_DR && ir_r == 3'h1) |=>
      (id_sh_r[31:29] == REVISION && id_sh_r[11:1] == VENDOR &&
       id_sh_r[20:19] == 2'h1 && id_sh_r[0]);
  endproperty
  a_id_capture: assert property (p_id_capture)
    else $error("id word fields wrong after capture");

  property p_id_opts;
    @(posedge tck_i) disable iff (tap_rst)
    (state_r == CAP_DR && ir_r == 3'h1) |=>
      (id_sh_r[26:24] == PART.density_code &&
       id_sh_r[22:21] == PART.word_width_code &&
       id_sh_r[18] == PART.plus_gen && id_sh_r[17] == PART.sep_ports &&
       id_sh_r[16] == PART.read_latency && id_sh_r[15] == PART.burst4 &&
       id_sh_r[13] == PART.sep_io && id_sh_r[27] == PART.odt &&
       id_sh_r[14] == PART.odt);
  endproperty
  a_id_opts: assert property (p_id_opts)
    else $error("part option bits wrong");

  property p_id_first;
    @(posedge tck_i) disable iff (tap_rst)
    (state_r == SH_DR && $past(state_r) == CAP_DR && ir_r == 3'h1)
      |-> tdo_o;
  endproperty
  a_id_first: assert property (p_id_first)
    else $error("start bit not first out");

  property p_bypass;
    @(posedge tck_i) disable iff (tap_rst)
    (state_r == SH_DR && ir_r == 3'h7 && $past(state_r) == SH_DR &&
     $past(tap_rst) == 1'b0) |-> tdo_o == byp_r && byp_r ==
      $past(scan_i.tdi);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass path broken");

  property p_bsr_path;
    @(posedge tck_i) disable iff (tap_rst)
    (state_r == SH_DR && (ir_r == 3'h0 || ir_r == 3'h2 || ir_r == 3'h4))
      |-> tdo_o == bsr_sh_r[0] ##1 bsr_sh_r[108] == $past(scan_i.tdi);
  endproperty
  a_bsr_path: assert property (p_bsr_path)
    else $error("boundary path not selected");

  property p_samplez_hiz;
    @(posedge tck_i) disable iff (tap_rst)
    (ir_r == 3'h2 && $past(ir_r) == 3'h2) |-> !q_drive_o;
  endproperty
  a_samplez_hiz: assert property (p_samplez_hiz)
    else $error("outputs driven during high-z sample");

  property p_tdo_oe;
    @(posedge tck_i) disable iff (tap_rst)
    $past(tap_rst) == 1'b0 |->
      tdo_oe_o == (state_r == SH_DR || state_r == SH_IR);
  endproperty
  a_tdo_oe: assert property (p_tdo_oe)
    else $error("tdo enable outside shift");

  property p_instr_cross;
    @(posedge clk_i) disable iff (rst_i)
    instr_upd_o |-> instr_o == ir_r;
  endproperty
  a_instr_cross: assert property (p_instr_cross)
    else $error("crossed instruction mismatch");

  c_id_shift: cover property (@(posedge tck_i) disable iff (tap_rst)
    state_r == SH_DR && ir_r == 3'h1);
  c_bypass: cover property (@(posedge tck_i) disable iff (tap_rst)
    state_r == SH_DR && ir_r == 3'h7);
  c_extest_drive: cover property (@(posedge tck_i) disable iff (tap_rst)
    ir_r == 3'h0 && q_drive_o);
  c_instr_upd: cover property (@(posedge clk_i) disable iff (rst_i)
    instr_upd_o && instr_o == 3'h4);

endmodule // spid_tap

// *** sim/spid_ctl_model.sv ***
// Purpose: Behavioural scan controller that drives the test access port.
// Assumes: Scan clock runs only inside frames, 80 ns period.
// Notes:   tms/tdi change just after falling tck; tdo sampled on rising.
`timescale 1ns/1ns

module spid_ctl_model
  import spid_pkg::*;
(
  // Scan link
  output logic tck_o,
  output spid_scan_in_t scan_o,
  input wire logic tdo_i
);

  // ----------------------------------------------------------------
  // Link primitives
  // ----------------------------------------------------------------
  // Clock parked low between frames
  initial
  begin
    tck_o = 1'b0;
    scan_o = '0;
  end

  // One scan period; the 37 ns lead keeps tck out of phase with clk_i
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    scan_o = '{tms: tms, tdi: tdi};
    #37 tck_o = 1'b1;
    tdo = tdo_i; // Stable since the previous falling edge
    #40 tck_o = 1'b0;
    #3;
  endtask

  // Six high tms edges force test-logic-reset, then park in idle
  task automatic reset_tap();
    logic t;
    repeat (6) tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
  endtask

  // Shifts n bits through IR or DR from idle, LSB first, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] d,
    output logic [127:0] q);
    logic t;
    q = '0;
    tick(1'b1, 1'b0, t);
    if (ir)
      tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
    tick(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++)
      tick(i == n - 1, d[i], q[i]);
    tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
  endtask

  // Loads an instruction; reserved codes are never sent
  task automatic load_ir(input logic [2:0] c, output logic [2:0] cap);
    logic [127:0] q;
    cap = '0;
    if (c inside {3'h3, 3'h5, 3'h6})
      return;
    scan(1'b1, 3, {125'h0, c}, q);
    cap = q[2:0];
  endtask

endmodule // spid_ctl_model

// *** sim/scan_port_instruction_id_test.sv ***
// Purpose: Self-checking bench for the scan port instruction logic.
// Assumes: Part options differ from the design defaults in every flag.
// Notes:   Expected identification word is assembled by hand below.
`timescale 1ns/1ns

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end

module scan_port_instruction_id_test
  import spid_pkg::*;
;

  // ----------------------------------------------------------------
  // Set-up
  // ----------------------------------------------------------------
  localparam logic [2:0] REV = 3'h5;
  localparam logic [10:0] VEN = 11'h2a3; // Arbitrary value
  localparam spid_part_t PART = '{DENS_72MB, WIDTH_X18, 1'b1, 1'b0, 1'b1,
    1'b1, 1'b0, 1'b1};
  // Rev, 0, odt, density 72, 0, x18, 01, flags 1011100, vendor, start
  localparam logic [31:0] ID_EXP = {REV, 2'h1, 3'h3, 1'h0, 2'h2, 2'h1,
    7'h5c, VEN, 1'h1};

  logic clk_i, rst_i, tck, tdo, tdo_oe, instr_upd, q_drive;
  logic [2:0] instr;
  spid_scan_in_t scan;
  logic [BSR_LEN-1:0] pins, preload, pre_exp;
  int errors, checked, seed, upd_cnt;

  spid_tap #(.REVISION(REV), .PART(PART), .VENDOR(VEN)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .instr_o(instr),
    .instr_upd_o(instr_upd), .tck_i(tck), .scan_i(scan), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .bsr_pins_i(pins), .preload_o(preload),
    .q_drive_o(q_drive));

  spid_ctl_model ctl (.tck_o(tck), .scan_o(scan), .tdo_i(tdo));

  // System clock
  initial
    clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  // Counts status pulses seen in the clk domain
  always @(posedge clk_i)
    if (instr_upd === 1'b1)
      upd_cnt <= upd_cnt + 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [127:0] rnd();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction

  // Output bus drive expected for an instruction and latched cell 109
  function automatic logic exp_q(input logic [2:0] c, input logic p);
    return (c == 3'h2) ? 1'b0 : (c == 3'h0) ? p : 1'b1;
  endfunction

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs about 40 us
  initial
  begin
    #200000;
    errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin : main
    logic [2:0] cap;
    logic [127:0] d, q;
    logic [2:0] codes [5];
    int n;
    codes = '{3'h0, 3'h2, 3'h4, 3'h1, 3'h7};
    seed = 8966;
    errors = 0;
    checked = 0;
    rst_i = 1'b1;
    pins = '0;
    pre_exp = '0;
    repeat (6) @(posedge clk_i);
    // The tck side synchroniser only sees reset while tck runs
    ctl.reset_tap();
    @(posedge clk_i);
    rst_i <= 1'b0;
    ctl.reset_tap();
    repeat (10) @(posedge clk_i);
    `CHK(instr, 3'h1)
    `CHK(q_drive, 1'b1)
    ctl.scan(1'b0, 32, rnd(), q);
    `CHK(q[31:0], ID_EXP)
    `CHK(tdo_oe, 1'b0)
    // Every defined instruction, boundary ones first
    foreach (codes[k])
    begin
      n = upd_cnt;
      ctl.load_ir(codes[k], cap);
      repeat (10) @(posedge clk_i);
      `CHK(cap[1:0], 2'h1)
      `CHK(instr, codes[k])
      `CHK(upd_cnt, n + 1)
      `CHK(q_drive, exp_q(codes[k], pre_exp[108]))
      d = rnd();
      if (codes[k] == 3'h1)
      begin
        ctl.scan(1'b0, 32, d, q);
        `CHK(q[31:0], ID_EXP)
      end
      else if (codes[k] == 3'h7)
      begin
        ctl.scan(1'b0, 8, d, q);
        `CHK(q[7:0], {d[6:0], 1'b0})
      end
      else
      begin
        // Cell 109 set only under the first instruction, to flip q_drive
        d[108] = (codes[k] == 3'h0);
        q = rnd();
        @(posedge clk_i);
        pins <= q[108:0];
        @(posedge clk_i);
        ctl.scan(1'b0, BSR_LEN, d, q);
        `CHK(q[107:0], pins[107:0])
        `CHK(q[108], pre_exp[108])
        if (codes[k] != 3'h2)
          pre_exp = d[108:0];
        `CHK(preload, pre_exp)
        `CHK(q_drive, exp_q(codes[k], pre_exp[108]))
      end
    end
    // Forced reset restores the identification instruction
    n = upd_cnt;
    ctl.reset_tap();
    repeat (10) @(posedge clk_i);
    `CHK(instr, 3'h1)
    `CHK(upd_cnt, n + 1)
    print_verdict();
  end

endmodule // scan_port_instruction_id_test
